// ### dv/qmc_engine_model.sv
// engine and parameter block memory standing behind the front end
`default_nettype none
`include "qmc_defines.svh"
module qmc_engine_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // parameter block
  input  wire logic        pb_rd,
  input  wire logic [7:0]  pb_addr,
  input  wire logic [15:0] w_hi,
  input  wire logic [15:0] w_lo,
  output logic      [15:0] pb_data,
  // flush engine
  input  wire logic        flush_req,
  input  wire logic        err_mode,
  input  wire logic [3:0]  dly,
  output logic             flush_done,
  output logic             flush_err
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_r;
  logic       busy_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pb_data    <= 16'h0000;
      cnt_r      <= 4'h0;
      busy_r     <= 1'b0;
      flush_done <= 1'b0;
      flush_err  <= 1'b0;
    end else begin
      // idle bus and error line keep changing so stale values never pass
      pb_data    <= ~pb_data;
      flush_err  <= ~flush_err;
      flush_done <= 1'b0;
      if (pb_rd && pb_addr == `QMC_PB_SG_HI) pb_data <= w_hi;
      if (pb_rd && pb_addr == `QMC_PB_SG_LO) pb_data <= w_lo;
      if (flush_req && !busy_r) begin
        busy_r <= 1'b1;
        cnt_r  <= dly;
      end else if (busy_r && cnt_r != 4'h0) begin
        cnt_r <= cnt_r - 4'h1;
      end else if (busy_r) begin
        busy_r     <= 1'b0;
        flush_done <= 1'b1;
        flush_err  <= err_mode;
      end
    end
  end
endmodule : qmc_engine_model
`default_nettype wire

// ### dv/qmc_tb_top.sv
// self-checking bench of the queue-mode front end
`default_nettype none
`include "qmc_defines.svh"
module qmc_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import qmc_pkg::*;
  logic        CLK = 1'b0, NRST = 1'b0, VIACK = 1'b0, REC_NORMAL = 1'b0, REC_ERROR = 1'b0;
  qmc_wb_req_t WB_REQ = '0;
  logic        WB_ACK, FLUSH_REQ, FLUSH_REPORT, FLUSH_ALL, BUS_RESET_REQ, SCSI_CMD_REQ;
  logic        FLUSH_DONE, FLUSH_ERR, PB_RD, INT, err_mode = 1'b0;
  logic [31:0] WB_DAT_O, v;
  logic [15:0] PB_DATA, nv, ev, r, w_hi = '0, w_lo = '0, lfsr_r = 16'h5CC0;
  logic [7:0]  PB_ADDR, VIRQ_VECTOR;
  logic [7:1]  VIRQ;
  logic [1:0]  BUS_REQ_LEVEL;
  logic [3:0]  dly = 4'h0;
  int          bad_count = 0, cmp_count = 0, n_rst = 0, n_scsi = 0;
  logic [31:0] bad_f [4] = '{32'h100, 32'h200, 32'hE00, 32'hC0};

  qmc_top DUT (.CLK(CLK), .NRST(NRST), .WB_REQ(WB_REQ), .WB_ACK(WB_ACK), .WB_DAT_O(WB_DAT_O),
    .FLUSH_REQ(FLUSH_REQ), .FLUSH_REPORT(FLUSH_REPORT), .FLUSH_ALL(FLUSH_ALL),
    .BUS_RESET_REQ(BUS_RESET_REQ), .SCSI_CMD_REQ(SCSI_CMD_REQ), .FLUSH_DONE(FLUSH_DONE),
    .FLUSH_ERR(FLUSH_ERR), .REC_NORMAL(REC_NORMAL), .REC_ERROR(REC_ERROR), .PB_RD(PB_RD),
    .PB_ADDR(PB_ADDR), .PB_DATA(PB_DATA), .VIRQ(VIRQ), .VIRQ_VECTOR(VIRQ_VECTOR), .VIACK(VIACK),
    .BUS_REQ_LEVEL(BUS_REQ_LEVEL), .INT(INT));
  qmc_engine_model u_eng (.clk(CLK), .nrst(NRST), .pb_rd(PB_RD), .pb_addr(PB_ADDR), .w_hi(w_hi),
    .w_lo(w_lo), .pb_data(PB_DATA), .flush_req(FLUSH_REQ), .err_mode(err_mode), .dly(dly),
    .flush_done(FLUSH_DONE), .flush_err(FLUSH_ERR));

  always #5 CLK = ~CLK;
  always @(posedge CLK) begin
    if (BUS_RESET_REQ === 1'b1) n_rst++;
    if (SCSI_CMD_REQ === 1'b1) n_scsi++;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] rnd();
    lfsr_r = {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
    return lfsr_r;
  endfunction : rnd
  function automatic logic [31:0] exp_virq(input logic [15:0] vec);
    return (vec[10:8] == 3'h0) ? 32'h0 : 32'h1 << vec[10:8];
  endfunction : exp_virq
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge CLK);
    WB_REQ <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: d};
    do begin
      @(posedge CLK);
      n++;
    end while (WB_ACK !== 1'b1 && n < 50);
    if (WB_ACK !== 1'b1) begin
      bad_count++;
      summarize();
    end
    q = WB_DAT_O;
    WB_REQ <= '0;
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] t;
    wb(1'b1, a, d, t);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    wb(1'b0, a, 32'h0, q);
  endtask : rd
  // opcode in bits 7:4, go in bit 1
  task automatic go(input logic [3:0] op, input logic [31:0] f);
    wr(`QMC_OFF_CTRL, {24'h000000, op, 4'h2} | f);
  endtask : go
  task automatic poll(input logic [31:0] m);
    int n;
    n = 0;
    do begin
      rd(`QMC_OFF_ISTAT, v);
      n++;
    end while ((v & m) === 32'h0 && n < 40);
    if ((v & m) === 32'h0) begin
      bad_count++;
      summarize();
    end
  endtask : poll
  task automatic rec(input logic e);
    REC_NORMAL <= !e;
    REC_ERROR  <= e;
    @(posedge CLK);
    REC_NORMAL <= 1'b0;
    REC_ERROR  <= 1'b0;
  endtask : rec
  task automatic irq_chk(input logic [15:0] vec);
    int n;
    n = 0;
    while (VIRQ === 7'h00 && n < 200) begin
      @(posedge CLK);
      n++;
    end
    chk(32'({VIRQ, 1'b0}), exp_virq(vec));
    chk(32'(VIRQ_VECTOR), 32'(vec[7:0]));
    VIACK <= 1'b1;
    @(posedge CLK);
    VIACK <= 1'b0;
    repeat (2) @(posedge CLK);
    chk(32'(VIRQ), 32'h0);
  endtask : irq_chk

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge CLK);
    NRST <= 1'b1;
    rd(`QMC_OFF_NVEC, v); chk(v, 32'(`QMC_VEC_RST));
    rd(`QMC_OFF_RESP, v); chk(v, 32'h0);
    wr(`QMC_OFF_IMASK, 32'hF);
    wr(`QMC_OFF_CTRL, 32'h1);
    rd(`QMC_OFF_RESP, v); chk(v & 32'h20, 32'h20);
    rd(`QMC_OFF_ISTAT, v); chk({v[30:0], INT}, 32'h0);
    chk(32'(VIRQ), 32'h0);
    for (int l = 1; l < 8; l++) begin
      r = rnd();
      nv = {5'h00, 3'(l), r[7:0]};
      ev = {5'h00, 3'(8 - l), r[15:8]};
      wr(`QMC_OFF_NVEC, 32'(nv));
      wr(`QMC_OFF_EVEC, 32'(ev));
      rec(1'b0); irq_chk(nv);
      rec(1'b1); irq_chk(ev);
      rd(`QMC_OFF_NVEC, v); chk(v, 32'(nv));
      rd(`QMC_OFF_EVEC, v); chk(v, 32'(ev));
    end
    for (int k = 0; k < 4; k++) begin
      err_mode <= k[0];
      dly      <= 4'(rnd());
      go(k[1] ? `QMC_OP_FLUSH_RPT : `QMC_OP_FLUSH_ALL, 32'h0);
      chk(32'({FLUSH_REPORT, FLUSH_ALL}), k[1] ? 32'h3 : 32'h1);
      irq_chk(k[0] ? ev : nv);
      rd(`QMC_OFF_ISTAT, v); chk(v & 32'h3, k[0] ? 32'h2 : 32'h1);
      wr(`QMC_OFF_ISTAT, 32'h3);
    end
    chk(n_rst, 0);
    err_mode <= 1'b0;
    wr(`QMC_OFF_IMASK, 32'h0);
    go(`QMC_OP_FLUSH_WQ, 32'h1000);
    poll(32'h1);
    chk({INT, VIRQ, 24'h0}, 32'h0);
    wr(`QMC_OFF_IMASK, 32'hF);
    @(posedge CLK); chk(32'(INT), 32'h1);
    wr(`QMC_OFF_ISTAT, 32'h1);
    @(posedge CLK); chk(32'(INT), 32'h0);
    chk(n_rst, 0);
    go(`QMC_OP_BUS_RST, 32'h0);
    repeat (2) @(posedge CLK); chk(n_rst, 1);
    w_hi <= rnd();
    w_lo <= rnd();
    go(`QMC_OP_SCSI_SG, 32'h0);
    poll(32'h8);
    rd(`QMC_OFF_SGCNT, v); chk(v, {w_hi, w_lo});
    foreach (bad_f[i]) begin
      wr(`QMC_OFF_ISTAT, 32'h4);
      go(`QMC_OP_SCSI, bad_f[i]);
      poll(32'h4); chk(n_scsi, 0);
    end
    go(`QMC_OP_SCSI, 32'h0);
    repeat (2) @(posedge CLK); chk(n_scsi, 1);
    for (int i = 0; i < 4; i++) begin
      wr(`QMC_OFF_CFG, 32'(i));
      chk(32'(BUS_REQ_LEVEL), 32'(i));
    end
    rd(8'h40, v); chk(v, 32'h0);
    summarize();
  end
endmodule : qmc_tb_top
`default_nettype wire

// ### inc/qmc_defines.svh
// constants of the queue-mode and controller-vector front end
//
// Notes on behaviour
// [RQ1] Setting the queue start request bit makes the adapter set the queue started flag, bit 5 of the status word.
// [RQ2] Entering queued mode raises no interrupt of any kind; the host polls the flag.
// [RQ3] Successful flush-all completions and normal recovery events go out on the normal completion vector.
// [RQ4] The normal vector holds the vector number in bits 0-7 and the level in bits 8-10, used for every normal interrupt.
// [RQ5] Failed flush-all completions and recovery error events go out on the error completion vector.
// [RQ6] The error vector holds the vector number in bits 0-7 and the level in bits 8-10, used for every error interrupt.
// [RQ7] Flush-queue-and-report never resets the SCSI bus; only the reset-bus command does.
// [RQ8] The reset-on-active-command option of flush-work-queue is ignored.
// [RQ9] The total scatter/gather count is read from parameter block words 0x0C and 0x0D.
// [RQ10] Linked commands and commands to a nonzero logical unit are rejected.
// [RQ11] The backplane interrupter requests on any level 1 to 7 and gives its vector at acknowledge.
// [RQ12] The bus requester uses one of request levels 0 to 3, chosen statically.
// [RQ13] Both vectors keep their host-written number and level until the host rewrites them.
`ifndef QMC_DEFINES_SVH
`define QMC_DEFINES_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define QMC_OFF_CTRL     8'h00
`define QMC_OFF_RESP     8'h04
`define QMC_OFF_NVEC     8'h08
`define QMC_OFF_EVEC     8'h0C
`define QMC_OFF_SGCNT    8'h10
`define QMC_OFF_CFG      8'h14
`define QMC_OFF_ISTAT    8'h18
`define QMC_OFF_IMASK    8'h1C

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define QMC_CTRL_QSTART  0
`define QMC_CTRL_GO      1
`define QMC_RESP_BUSY    0
`define QMC_RESP_QSTART  5
`define QMC_OP_FLUSH_ALL 4'h1
`define QMC_OP_FLUSH_RPT 4'h2
`define QMC_OP_FLUSH_WQ  4'h3
`define QMC_OP_BUS_RST   4'h4
`define QMC_OP_SCSI      4'h5
`define QMC_OP_SCSI_SG   4'h6
`define QMC_EV_FLUSH_OK  0
`define QMC_EV_FLUSH_ERR 1
`define QMC_EV_REJECT    2
`define QMC_EV_SG_DONE   3

// ----------------------------------------------------------------
// parameter block and reset values
// ----------------------------------------------------------------
`define QMC_PB_SG_HI     8'h0C
`define QMC_PB_SG_LO     8'h0D
`define QMC_VEC_RST      16'h0000
`define QMC_CFG_RST      8'h00
`define QMC_EV_W         4

`endif

// ### inc/qmc_pkg.sv
// types of the queue-mode and controller-vector front end
`default_nettype none
package qmc_pkg;
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } qmc_wb_req_t;

  typedef struct packed {
    logic [4:0] rsvd;
    logic [2:0] level;
    logic [7:0] number;
  } qmc_vec_t;

  // command word written to the control register; opcode kept clear of the start and go bits
  typedef struct packed {
    logic [18:0] rsvd;
    logic        bus_reset_on_active_cmd;
    logic [2:0]  lun;
    logic        linked;
    logic [3:0]  opcode;
    logic [3:0]  ctl;
  } qmc_cmd_t;

  typedef enum logic [1:0] {
    QMC_IDLE    = 2'b00,
    QMC_FLUSH   = 2'b01,
    QMC_SG_HI   = 2'b10,
    QMC_SG_LO   = 2'b11
  } qmc_state_t;
endpackage : qmc_pkg
`default_nettype wire

// ### logic/qmc_top.sv
// queue-mode command front end with controller completion vectors
`default_nettype none
`include "qmc_defines.svh"
module qmc_top (
  // clock and reset
  input  wire logic                 CLK,
  input  wire logic                 NRST,
  // wishbone slave
  input  wire qmc_pkg::qmc_wb_req_t WB_REQ,
  output logic                      WB_ACK,
  output logic [31:0]               WB_DAT_O,
  // adapter engine, same clock
  output logic                      FLUSH_REQ,
  output logic                      FLUSH_REPORT,
  output logic                      FLUSH_ALL,
  output logic                      BUS_RESET_REQ,
  output logic                      SCSI_CMD_REQ,
  input  wire logic                 FLUSH_DONE,
  input  wire logic                 FLUSH_ERR,
  input  wire logic                 REC_NORMAL,
  input  wire logic                 REC_ERROR,
  // parameter block reader, one cycle latency
  output logic                      PB_RD,
  output logic [7:0]                PB_ADDR,
  input  wire logic [15:0]          PB_DATA,
  // backplane interrupter and requester
  output logic [7:1]                VIRQ,
  output logic [7:0]                VIRQ_VECTOR,
  input  wire logic                 VIACK,
  output logic [1:0]                BUS_REQ_LEVEL,
  // local interrupt
  output logic                      INT
);
  import qmc_pkg::*;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic       ack_r;
  logic [31:0] rdat_r;
  wire  req    = WB_REQ.cyc && WB_REQ.stb && !ack_r;
  wire  wr     = req && WB_REQ.we;
  wire  hit_ctrl  = WB_REQ.adr == `QMC_OFF_CTRL;
  wire  hit_nvec  = WB_REQ.adr == `QMC_OFF_NVEC;
  wire  hit_evec  = WB_REQ.adr == `QMC_OFF_EVEC;
  wire  hit_cfg   = WB_REQ.adr == `QMC_OFF_CFG;
  wire  hit_istat = WB_REQ.adr == `QMC_OFF_ISTAT;
  wire  hit_imask = WB_REQ.adr == `QMC_OFF_IMASK;
  wire  wr_ctrl  = wr && hit_ctrl && WB_REQ.sel[0];
  wire  wr_cfg   = wr && hit_cfg && WB_REQ.sel[0];
  wire  wr_istat = wr && hit_istat && WB_REQ.sel[0];
  wire  wr_imask = wr && hit_imask && WB_REQ.sel[0];
  qmc_cmd_t cmd;
  assign cmd = WB_REQ.dat;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  qmc_state_t state_r, state_nxt;
  logic       qstarted_r;
  logic [31:0] sgcnt_r, sgcnt_nxt;
  logic [7:0] cfg_r;
  logic [`QMC_EV_W-1:0] istat_r, istat_nxt, imask_r, ev;
  logic       npend_r, epend_r;
  qmc_vec_t   nvec, evec;
  logic       flush_rpt_r, flush_all_r;

  // ----------------------------------------------------------------
  // vectors
  // ----------------------------------------------------------------
  qmc_vec_reg u_nvec (
    .clk  (CLK),
    .nrst (NRST),
    .wr   (wr && hit_nvec),
    .be   (WB_REQ.sel[1:0]),
    .wdat (WB_REQ.dat[15:0]),
    .vec  (nvec)
  );

  qmc_vec_reg u_evec (
    .clk  (CLK),
    .nrst (NRST),
    .wr   (wr && hit_evec),
    .be   (WB_REQ.sel[1:0]),
    .wdat (WB_REQ.dat[15:0]),
    .vec  (evec)
  );

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  wire go       = wr_ctrl && cmd[`QMC_CTRL_GO];
  wire idle     = state_r == QMC_IDLE;
  wire is_flush = cmd.opcode == `QMC_OP_FLUSH_ALL || cmd.opcode == `QMC_OP_FLUSH_RPT
               || cmd.opcode == `QMC_OP_FLUSH_WQ;
  wire is_scsi  = cmd.opcode == `QMC_OP_SCSI || cmd.opcode == `QMC_OP_SCSI_SG;
  // link and lun fields are checked before anything starts
  wire bad_scsi = is_scsi && (cmd.linked || cmd.lun != 3'h0);        // [RQ10]
  wire known    = is_flush || is_scsi || cmd.opcode == `QMC_OP_BUS_RST;
  wire accept   = go && idle && known && !bad_scsi;
  wire reject   = go && !(idle && known && !bad_scsi);               // [RQ10]

  // flush never drives the bus reset; the option bit is not looked at
  assign BUS_RESET_REQ = accept && cmd.opcode == `QMC_OP_BUS_RST;    // [RQ7] [RQ8]
  assign FLUSH_REQ     = accept && is_flush;
  assign SCSI_CMD_REQ  = accept && cmd.opcode == `QMC_OP_SCSI;
  assign FLUSH_REPORT  = flush_rpt_r;
  assign FLUSH_ALL     = flush_all_r;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      QMC_IDLE: begin
        if (accept && is_flush) begin
          state_nxt = QMC_FLUSH;
        end else if (accept && cmd.opcode == `QMC_OP_SCSI_SG) begin
          state_nxt = QMC_SG_HI;
        end
      end
      QMC_FLUSH: begin
        if (FLUSH_DONE) begin
          state_nxt = QMC_IDLE;
        end
      end
      QMC_SG_HI: state_nxt = QMC_SG_LO;
      QMC_SG_LO: state_nxt = QMC_IDLE;
      default:   state_nxt = QMC_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // scatter/gather count fetch
  // ----------------------------------------------------------------
  // high word first, high word arrives while the second read, of the low word, is out
  assign PB_RD   = state_r == QMC_SG_HI || (accept && cmd.opcode == `QMC_OP_SCSI_SG);
  assign PB_ADDR = state_r == QMC_SG_HI ? `QMC_PB_SG_LO : `QMC_PB_SG_HI; // [RQ9]
  always_comb begin
    sgcnt_nxt = sgcnt_r;
    if (state_r == QMC_SG_HI) begin
      sgcnt_nxt[31:16] = PB_DATA;                                    // [RQ9]
    end else if (state_r == QMC_SG_LO) begin
      sgcnt_nxt[15:0] = PB_DATA;                                     // [RQ9]
    end
  end

  // ----------------------------------------------------------------
  // events; queue start is deliberately absent
  // ----------------------------------------------------------------
  wire flush_fin = state_r == QMC_FLUSH && FLUSH_DONE;
  wire all_fin   = flush_fin && flush_all_r;
  assign ev[`QMC_EV_FLUSH_OK]  = flush_fin && !FLUSH_ERR;
  assign ev[`QMC_EV_FLUSH_ERR] = flush_fin && FLUSH_ERR;
  assign ev[`QMC_EV_REJECT]    = reject;
  assign ev[`QMC_EV_SG_DONE]   = state_r == QMC_SG_LO;
  // set wins over a write-one clear in the same cycle
  assign istat_nxt = (istat_r & ~(wr_istat ? WB_REQ.dat[`QMC_EV_W-1:0] : 4'h0)) | ev;
  assign INT = |(istat_r & imask_r);                                 // [RQ2]

  // ----------------------------------------------------------------
  // controller interrupter
  // ----------------------------------------------------------------
  wire n_set = (all_fin && !FLUSH_ERR) || REC_NORMAL;                // [RQ3]
  wire e_set = (all_fin && FLUSH_ERR) || REC_ERROR;                  // [RQ5]
  // error is served first; its vector is picked at acknowledge time
  wire      serve_err = epend_r;
  qmc_vec_t act_vec;
  assign act_vec = serve_err ? evec : nvec;                          // [RQ4] [RQ6]
  wire      pend    = epend_r || npend_r;
  // level zero means the interrupter stays quiet
  genvar gl;
  for (gl = 1; gl <= 7; gl++) begin : g_virq
    assign VIRQ[gl] = pend && act_vec.level == 3'(gl);               // [RQ11]
  end
  assign VIRQ_VECTOR   = pend ? act_vec.number : 8'h00;              // [RQ11]
  assign BUS_REQ_LEVEL = cfg_r[1:0];                                 // [RQ12]

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      state_r     <= QMC_IDLE;
      qstarted_r  <= 1'b0;
      sgcnt_r     <= 32'h00000000;
      cfg_r       <= `QMC_CFG_RST;
      istat_r     <= 4'h0;
      imask_r     <= 4'h0;
      npend_r     <= 1'b0;
      epend_r     <= 1'b0;
      flush_rpt_r <= 1'b0;
      flush_all_r <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      sgcnt_r    <= sgcnt_nxt;
      istat_r    <= istat_nxt;
      qstarted_r <= qstarted_r || (wr_ctrl && cmd[`QMC_CTRL_QSTART]); // [RQ1]
      if (wr_cfg) begin
        cfg_r <= {6'h00, WB_REQ.dat[1:0]};                           // [RQ12]
      end
      if (wr_imask) begin
        imask_r <= WB_REQ.dat[`QMC_EV_W-1:0];
      end
      if (accept && is_flush) begin
        flush_rpt_r <= cmd.opcode == `QMC_OP_FLUSH_RPT;
        flush_all_r <= cmd.opcode != `QMC_OP_FLUSH_WQ;
      end
      npend_r <= n_set || (npend_r && !(VIACK && !serve_err));
      epend_r <= e_set || (epend_r && !(VIACK && serve_err));
    end
  end

  // ----------------------------------------------------------------
  // bus answer, one cycle after the request
  // ----------------------------------------------------------------
  logic [31:0] rsel;
  always_comb begin
    rsel = 32'h00000000;
    case (WB_REQ.adr)
      `QMC_OFF_RESP:  rsel = {26'h0, qstarted_r, 4'h0, !idle};      // [RQ1]
      `QMC_OFF_NVEC:  rsel = {16'h0000, nvec};
      `QMC_OFF_EVEC:  rsel = {16'h0000, evec};
      `QMC_OFF_SGCNT: rsel = sgcnt_r;
      `QMC_OFF_CFG:   rsel = {24'h000000, cfg_r};
      `QMC_OFF_ISTAT: rsel = {28'h0000000, istat_r};
      `QMC_OFF_IMASK: rsel = {28'h0000000, imask_r};
      default:        rsel = 32'h00000000;
    endcase
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ack_r  <= 1'b0;
      rdat_r <= 32'h00000000;
    end else begin
      ack_r  <= req;
      rdat_r <= req && !WB_REQ.we ? rsel : 32'h00000000;
    end
  end
  assign WB_ACK   = ack_r;
  assign WB_DAT_O = rdat_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_qstart_flag;
    @(posedge CLK) disable iff (!NRST)
    (wr_ctrl && cmd[`QMC_CTRL_QSTART]) |=> qstarted_r [*3];
  endproperty
  a_qstart_flag: assert property (p_qstart_flag) else $error("queue flag not set"); // [RQ1]

  property p_qstart_quiet;
    @(posedge CLK) disable iff (!NRST)
    (wr_ctrl && cmd[`QMC_CTRL_QSTART] && !go && istat_r == 4'h0 && !pend && !ev[`QMC_EV_FLUSH_OK]
     && !ev[`QMC_EV_FLUSH_ERR] && !ev[`QMC_EV_SG_DONE] && !REC_NORMAL && !REC_ERROR) |=> (!INT && !pend);
  endproperty
  a_qstart_quiet: assert property (p_qstart_quiet) else $error("queue start raised interrupt"); // [RQ2]

  property p_norm_vec;
    @(posedge CLK) disable iff (!NRST)
    (all_fin && !FLUSH_ERR && !epend_r && !e_set) |=> (VIRQ_VECTOR == nvec.number);
  endproperty
  a_norm_vec: assert property (p_norm_vec) else $error("normal completion used wrong vector"); // [RQ3]

  property p_norm_level;
    @(posedge CLK) disable iff (!NRST)
    (npend_r && !epend_r && nvec.level != 3'h0) |-> VIRQ[nvec.level];
  endproperty
  a_norm_level: assert property (p_norm_level) else $error("normal level not driven"); // [RQ4]

  property p_err_vec;
    @(posedge CLK) disable iff (!NRST)
    e_set |=> (VIRQ_VECTOR == evec.number);
  endproperty
  a_err_vec: assert property (p_err_vec) else $error("error completion used wrong vector"); // [RQ5]

  property p_err_level;
    @(posedge CLK) disable iff (!NRST)
    (epend_r && evec.level != 3'h0) |-> (VIRQ == 7'(1 << (evec.level - 3'h1)));
  endproperty
  a_err_level: assert property (p_err_level) else $error("error level not one-hot"); // [RQ6]

  property p_no_flush_reset;
    @(posedge CLK) disable iff (!NRST)
    FLUSH_REQ |-> !BUS_RESET_REQ;
  endproperty
  a_no_flush_reset: assert property (p_no_flush_reset) else $error("flush reset the bus"); // [RQ7] [RQ8]

  property p_sg_words;
    @(posedge CLK) disable iff (!NRST)
    (state_r == QMC_SG_HI) |-> ($past(PB_ADDR) == `QMC_PB_SG_HI && PB_ADDR == `QMC_PB_SG_LO) ##2 idle;
  endproperty
  a_sg_words: assert property (p_sg_words) else $error("count words fetched wrong"); // [RQ9]

  property p_reject_link;
    @(posedge CLK) disable iff (!NRST)
    (go && bad_scsi && idle) |-> !SCSI_CMD_REQ ##1 istat_r[`QMC_EV_REJECT] && idle;
  endproperty
  a_reject_link: assert property (p_reject_link) else $error("linked or lun command accepted"); // [RQ10]

  property p_virq_zero;
    @(posedge CLK) disable iff (!NRST)
    (!pend || act_vec.level == 3'h0) |-> VIRQ == 7'h00;
  endproperty
  a_virq_zero: assert property (p_virq_zero) else $error("interrupter active without level"); // [RQ11]

  property p_req_static;
    @(posedge CLK) disable iff (!NRST)
    !wr_cfg |=> $stable(BUS_REQ_LEVEL);
  endproperty
  a_req_static: assert property (p_req_static) else $error("requester level moved"); // [RQ12]

  property p_vec_hold;
    @(posedge CLK) disable iff (!NRST)
    !(wr && (hit_nvec || hit_evec)) |=> $stable(nvec) && $stable(evec);
  endproperty
  a_vec_hold: assert property (p_vec_hold) else $error("vector changed without write"); // [RQ13]
endmodule : qmc_top
`default_nettype wire

// ### logic/qmc_vec_reg.sv
// host-programmed completion vector register
`default_nettype none
`include "qmc_defines.svh"
module qmc_vec_reg (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             nrst,
  // write port
  input  wire logic             wr,
  input  wire logic [1:0]       be,
  input  wire logic [15:0]      wdat,
  // held value
  output qmc_pkg::qmc_vec_t     vec
);
  import qmc_pkg::*;
  qmc_vec_t vec_r;
  qmc_vec_t vec_nxt;

  // only host writes change it; reserved bits stay zero
  assign vec_nxt.number = (wr && be[0]) ? wdat[7:0] : vec_r.number;  // [RQ13]
  assign vec_nxt.level  = (wr && be[1]) ? wdat[10:8] : vec_r.level;  // [RQ13]
  assign vec_nxt.rsvd   = 5'h00;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      vec_r <= `QMC_VEC_RST;
    end else begin
      vec_r <= vec_nxt;
    end
  end

  assign vec = vec_r;
endmodule : qmc_vec_reg
`default_nettype wire
